//--- core/standby_mode_controller.v
// standby mode controller: run-mode tracking, cpu-halt and tg-halt standby, warm-up counter, clock switch
// assumes cpu pulses, time-base clock and wake inputs arrive from outside and are synchronised here
//
// What this block does
// - cpu-halt standby stops cpu and watchdog only
// - standby keeps memory, registers, latches frozen
// - held program counter is entry address plus 2
// - master enable off, then cpu-halt bit starts
// - cpu-halt exit clears bit, restores prior mode
// - reset pin ends cpu-halt, restarts single fast
// - master off: wake resumes, no handler run
// - master on: wake runs handler first
// - pending watchdog interrupt cancels standby entry
// - tg-halt gates all clocks except time base
// - peripherals stopped before tg-halt bit set
// - tg-halt exit clears bit, restores prior mode
// - time base enabled at entry sets latch
// - tg-halt ends on time base falling edge
// - tg-halt ignores time base enable
// - not all enables: resume next instruction
// - all enables: release starts time base service
// - async wake may shorten standby interval
// - reset pin ends tg-halt, restarts single fast
// - select slow clock before fast oscillator off
// - warm-up counter 43H/05H, done permits switch
// - reset if chosen or both oscillators off
`timescale 1ns/1ps
`include "standby_mode_map.vh"

module standby_mode_controller #(
    parameter WARMUP_WIDTH = 16
) (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // register port
    input wire [3:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [7:0] regRdData,
    // cpu side
    input wire [15:0] cpuPc,
    input wire [7:0] irqRequests,
    input wire [7:0] irqEnables,
    input wire watchdogIrq,
    output wire cpuRun,
    output wire watchdogRun,
    output wire stateHold,
    output reg [15:0] resumePc,
    output reg wakeNoService,
    output reg timeBaseService,
    output reg warmupDoneIrq,
    // oscillators and timing generator
    input wire timeBaseSrc,
    output wire fastOscEnable,
    output wire slowOscEnable,
    output wire mainClockSlow,
    output wire periphClockEnable,
    output wire timeBaseClockEnable,
    output reg sysResetReq
);

    localparam ST_RUN = 4'h1;
    localparam ST_CPU_HALT = 4'h2;
    localparam ST_TG_HALT = 4'h4;
    localparam ST_WAKE = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    reg tbSrcMeta;
    reg tbSrcSync;
    reg tbSrcLast;
    reg [7:0] irqMeta;
    reg [7:0] irqSync;
    reg wdMeta;
    reg wdSync;

    // the time base source idles high, so its flops reset high and no false edge follows reset
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tbSrcMeta <= 1'b1;
            tbSrcSync <= 1'b1;
            tbSrcLast <= 1'b1;
        end else begin
            tbSrcMeta <= timeBaseSrc;
            tbSrcSync <= tbSrcMeta;
            tbSrcLast <= tbSrcSync;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irqMeta <= 8'h00;
            irqSync <= 8'h00;
        end else begin
            irqMeta <= irqRequests;
            irqSync <= irqMeta;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wdMeta <= 1'b0;
            wdSync <= 1'b0;
        end else begin
            wdMeta <= watchdogIrq;
            wdSync <= wdMeta;
        end
    end

    // falling edge of the selected time base source; async wake can cut the period short
    wire tbFall = tbSrcLast & ~tbSrcSync;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    reg [7:0] powerModeCtrl_reg;
    reg [7:0] timeBaseCtrl_reg;
    reg [7:0] irqCtrl_reg;
    reg [7:0] warmupLowCtrl_reg;
    reg [7:0] warmupHighCtrl_reg;
    reg [WARMUP_WIDTH-1:0] warmupLimit_reg;
    reg [WARMUP_WIDTH-1:0] warmupCount_reg;
    reg [3:0] state_reg;
    reg savedClockSlow_reg;
    reg [3:0] state_next;

    wire wrPmc = regWrite && (regAddr == `ADDR_POWER_MODE_CTRL);
    wire [7:0] pmcWr = regWrData & `PMC_WRITE_MASK;
    wire masterEn = irqCtrl_reg[`IRQ_MASTER_EN];
    wire tbEnable = timeBaseCtrl_reg[`TBC_ENABLE];
    wire tbIrqEn = irqCtrl_reg[`IRQ_TB_EN];
    wire anyWake = |(irqSync & irqEnables);
    wire allTbEn = masterEn & tbIrqEn & tbEnable;
    wire warmupMode = (warmupLowCtrl_reg == `WARMUP_LOW_MODE) &&
        ((warmupHighCtrl_reg & `WARMUP_HIGH_MODE_MASK) == `WARMUP_HIGH_MODE);
    wire warmupRun = warmupMode & warmupHighCtrl_reg[`WARMUP_HIGH_START];
    wire warmupHit = warmupRun && (warmupCount_reg == warmupLimit_reg);

    // requests start standby unless a watchdog interrupt is already pending
    wire cpuHaltGo = (state_reg == ST_RUN) && powerModeCtrl_reg[`PMC_CPU_HALT_REQ] && !wdSync;
    wire tgHaltGo = (state_reg == ST_RUN) && powerModeCtrl_reg[`PMC_TG_HALT_REQ] &&
        !powerModeCtrl_reg[`PMC_CPU_HALT_REQ] && !wdSync;
    wire cpuHaltExit = (state_reg == ST_CPU_HALT) && anyWake;
    wire tgHaltExit = (state_reg == ST_TG_HALT) && tbFall;

    ////////////////////////////////////////////////////////////////////////////
    // mode state machine
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (cpuHaltGo || tgHaltGo)
                    state_next = cpuHaltGo ? ST_CPU_HALT : ST_TG_HALT;
            end
            ST_CPU_HALT: begin
                if (cpuHaltExit)
                    state_next = ST_WAKE;
            end
            ST_TG_HALT: begin
                if (tgHaltExit)
                    state_next = ST_WAKE;
            end
            ST_WAKE: begin
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            state_reg <= ST_RUN;
        else
            state_reg <= state_next;
    end

    // entry snapshot: the run mode and the address to resume from
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            savedClockSlow_reg <= 1'b0;
            resumePc <= 16'h0000;
        end else if (cpuHaltGo || tgHaltGo) begin
            savedClockSlow_reg <= powerModeCtrl_reg[`PMC_CLOCK_SELECT];
            resumePc <= cpuPc + `PC_STEP;
        end
    end

    // release pulses last one cycle, while the wake state stands
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wakeNoService <= 1'b0;
            timeBaseService <= 1'b0;
        end else begin
            wakeNoService <= 1'b0;
            timeBaseService <= 1'b0;
            if (cpuHaltExit)
                wakeNoService <= !masterEn;
            if (tgHaltExit) begin
                wakeNoService <= !allTbEn;
                timeBaseService <= allTbEn;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power mode control: software writes, hardware clears and clock restore
    reg [7:0] powerModeCtrl_next;
    wire cpuHaltDrop = powerModeCtrl_reg[`PMC_CPU_HALT_REQ] && (state_reg == ST_RUN) && wdSync;
    wire tgHaltDrop = powerModeCtrl_reg[`PMC_TG_HALT_REQ] && (state_reg == ST_RUN) && wdSync;

    always @* begin
        powerModeCtrl_next = powerModeCtrl_reg;
        if (wrPmc)
            powerModeCtrl_next = pmcWr;
        // requests clear themselves on release; a rejected request is dropped too
        if (cpuHaltExit || cpuHaltDrop)
            powerModeCtrl_next[`PMC_CPU_HALT_REQ] = 1'b0;
        if (tgHaltExit || tgHaltDrop)
            powerModeCtrl_next[`PMC_TG_HALT_REQ] = 1'b0;
        if (cpuHaltExit || tgHaltExit)
            powerModeCtrl_next[`PMC_CLOCK_SELECT] = savedClockSlow_reg;
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            powerModeCtrl_reg <= `PMC_RESET_VALUE;
        else
            powerModeCtrl_reg <= powerModeCtrl_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // time base control: the rate field is only stored, the source comes in on a pin
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            timeBaseCtrl_reg <= `TBC_RESET_VALUE;
        else if (regWrite && regAddr == `ADDR_TIME_BASE_CTRL)
            timeBaseCtrl_reg <= regWrData;
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt control: hardware sets win over a software clear in the same cycle
    reg [7:0] irqCtrl_next;

    always @* begin
        irqCtrl_next = irqCtrl_reg;
        if (regWrite && regAddr == `ADDR_IRQ_CTRL)
            irqCtrl_next = regWrData & `IRQ_WRITE_MASK;
        if (tgHaltGo && tbEnable)
            irqCtrl_next[`IRQ_TB_LATCH] = 1'b1;
        if (warmupHit)
            irqCtrl_next[`IRQ_WARMUP_LATCH] = 1'b1;
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            irqCtrl_reg <= `IRQ_RESET_VALUE;
        else
            irqCtrl_reg <= irqCtrl_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // warm-up set-up; only the low byte of the limit is writable
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            warmupLowCtrl_reg <= `WARMUP_CTRL_RESET;
            warmupHighCtrl_reg <= `WARMUP_CTRL_RESET;
            warmupLimit_reg <= `WARMUP_LIMIT_RESET;
        end else if (regWrite) begin
            if (regAddr == `ADDR_WARMUP_LOW_CTRL)
                warmupLowCtrl_reg <= regWrData;
            if (regAddr == `ADDR_WARMUP_HIGH_CTRL)
                warmupHighCtrl_reg <= regWrData;
            if (regAddr == `ADDR_WARMUP_LIMIT)
                warmupLimit_reg <= {warmupLimit_reg[WARMUP_WIDTH-1:8], regWrData};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // warm-up count: stops at the limit; software must stop and restart it
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            warmupCount_reg <= {WARMUP_WIDTH{1'b0}};
            warmupDoneIrq <= 1'b0;
        end else begin
            warmupDoneIrq <= warmupHit && irqCtrl_reg[`IRQ_WARMUP_EN] && masterEn;
            if (!warmupRun)
                warmupCount_reg <= {WARMUP_WIDTH{1'b0}};
            else if (!warmupHit)
                warmupCount_reg <= warmupCount_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // oscillator reset check: both off, or the selected one off
    wire fastEn = powerModeCtrl_reg[`PMC_FAST_OSC_EN];
    wire slowEn = powerModeCtrl_reg[`PMC_SLOW_OSC_EN];
    wire clkSel = powerModeCtrl_reg[`PMC_CLOCK_SELECT];
    wire bothOscOff = !fastEn && !slowEn;
    wire chosenOscOff = clkSel ? !slowEn : !fastEn;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            sysResetReq <= 1'b0;
        else
            sysResetReq <= bothOscOff || chosenOscOff;
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock and hold outputs
    assign fastOscEnable = fastEn;
    assign slowOscEnable = slowEn;
    assign mainClockSlow = clkSel;
    assign cpuRun = (state_reg == ST_RUN) || (state_reg == ST_WAKE);
    assign watchdogRun = cpuRun;
    assign stateHold = !cpuRun;
    assign periphClockEnable = (state_reg != ST_TG_HALT);
    assign timeBaseClockEnable = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // read port, data valid the cycle after the strobe
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            regRdData <= 8'h00;
        else if (regRead) begin
            case (regAddr)
                `ADDR_POWER_MODE_CTRL: regRdData <= powerModeCtrl_reg;
                `ADDR_TIME_BASE_CTRL: regRdData <= timeBaseCtrl_reg;
                `ADDR_IRQ_CTRL: regRdData <= irqCtrl_reg;
                `ADDR_WARMUP_LOW_CTRL: regRdData <= warmupLowCtrl_reg;
                `ADDR_WARMUP_HIGH_CTRL: regRdData <= warmupHighCtrl_reg;
                `ADDR_WARMUP_LIMIT: regRdData <= warmupLimit_reg[7:0];
                `ADDR_MODE_STATUS: regRdData <= {4'h0, state_reg};
                default: regRdData <= 8'h00;
            endcase
        end else
            regRdData <= 8'h00;
    end

endmodule // standby_mode_controller

//--- core/standby_mode_map.vh
// constants for the standby mode controller: register offsets, field positions, reset values, timing
// assumes an includer that wants plain defines; no logic here
`ifndef STANDBY_MODE_MAP_VH
`define STANDBY_MODE_MAP_VH

// register offsets (word addressed on the plain port)
`define ADDR_POWER_MODE_CTRL 4'h0
`define ADDR_TIME_BASE_CTRL 4'h1
`define ADDR_IRQ_CTRL 4'h2
`define ADDR_WARMUP_LOW_CTRL 4'h3
`define ADDR_WARMUP_HIGH_CTRL 4'h4
`define ADDR_WARMUP_LIMIT 4'h5
`define ADDR_MODE_STATUS 4'h6

// power_mode_ctrl_reg fields
`define PMC_FAST_OSC_EN 7
`define PMC_SLOW_OSC_EN 6
`define PMC_CLOCK_SELECT 5
`define PMC_CPU_HALT_REQ 4
`define PMC_TG_HALT_REQ 2
`define PMC_RESET_VALUE 8'h80
`define PMC_WRITE_MASK 8'hF4

// time_base_ctrl_reg fields
`define TBC_ENABLE 3
`define TBC_RATE_LSB 0
`define TBC_RATE_MSB 2
`define TBC_RESET_VALUE 8'h00

// irq control register fields
`define IRQ_MASTER_EN 0
`define IRQ_TB_EN 1
`define IRQ_WARMUP_EN 2
`define IRQ_TB_LATCH 3
`define IRQ_WARMUP_LATCH 4
`define IRQ_WRITE_MASK 8'h1F
`define IRQ_RESET_VALUE 8'h00

// warm-up counter set-up
`define WARMUP_LOW_MODE 8'h43
`define WARMUP_HIGH_MODE 8'h05
`define WARMUP_HIGH_MODE_MASK 8'hF7
`define WARMUP_HIGH_START 3
`define WARMUP_LIMIT_RESET 16'h8000
`define WARMUP_CTRL_RESET 8'h00

// program counter step across the standby entry instruction
`define PC_STEP 16'h0002

`endif

//--- test/cpu_side_model.sv
// cpu side model: interrupt latches and a gated time base source
// assumes the bench drives raise, clr and tbRun with nonblocking writes on clock edges, rising or falling
`timescale 1ns/1ps
module cpu_side_model (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // bench control
    input wire [7:0] raise,
    input wire clr,
    input wire tbRun,
    // toward the controller
    output reg [7:0] irqRequests,
    output reg timeBaseSrc
);
reg [2:0] tbCount;
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        irqRequests <= 8'h00;
        tbCount <= 3'h0;
        timeBaseSrc <= 1'h1;
    end else begin
        // a latch outlives the wake until software clears it
        irqRequests <= clr ? 8'h00 : irqRequests | raise;
        // source idles high, so no stray edge releases a gate halt
        tbCount <= tbRun ? tbCount + 3'h1 : 3'h0;
        timeBaseSrc <= ~(tbRun & tbCount[2]);
    end
end
endmodule // cpu_side_model

//--- test/standby_mode_controller_sva.sv
// checker for the standby mode controller, bound to every instance
// assumes only the controller's ports; one clock, asynchronous active-low reset
`timescale 1ns/1ps
module standby_mode_controller_sva (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // cpu side outputs
    input wire cpuRun,
    input wire watchdogRun,
    input wire stateHold,
    input wire [15:0] resumePc,
    input wire wakeNoService,
    input wire timeBaseService,
    // clock control outputs
    input wire fastOscEnable,
    input wire slowOscEnable,
    input wire mainClockSlow,
    input wire periphClockEnable,
    input wire timeBaseClockEnable,
    input wire sysResetReq
);
default clocking cb @(posedge clk_sys); endclocking
default disable iff (!rstn);
////////////////////////////////////////////////////////////////////////////
AST_WDT_FOLLOWS_CPU: assert property (watchdogRun == cpuRun && stateHold == !cpuRun)
    else $error("watchdog or hold disagrees with cpu run");
AST_TB_CLOCK_ON: assert property (timeBaseClockEnable)
    else $error("time base clock gated");
AST_PERIPH_GATE_HALTS: assert property (!periphClockEnable |-> !cpuRun)
    else $error("peripheral clock gated while cpu runs");
AST_PC_HELD: assert property (!cpuRun && !$past(cpuRun) |-> $stable(resumePc))
    else $error("resume address moved in standby");
AST_CLOCK_KEPT: assert property (!cpuRun |-> $stable(mainClockSlow) && $stable(fastOscEnable))
    else $error("clock setting moved in standby");
AST_WAKE_PLAIN: assert property (wakeNoService |-> $rose(cpuRun))
    else $error("plain wake without leaving standby");
AST_TB_SERVICE: assert property (timeBaseService |-> $rose(cpuRun) && !$past(periphClockEnable))
    else $error("time base service outside gate release");
AST_RESET_START: assert property ($rose(rstn) |-> cpuRun && fastOscEnable && !mainClockSlow)
    else $error("wrong mode after reset");
AST_OSC_RESET: assert property ((mainClockSlow ? !slowOscEnable : !fastOscEnable) |-> ##[0:1] sysResetReq)
    else $error("no reset for stopped main oscillator");
endmodule // standby_mode_controller_sva
bind standby_mode_controller standby_mode_controller_sva sva_u (.clk_sys(clk_sys), .rstn(rstn), .cpuRun(cpuRun),
    .watchdogRun(watchdogRun), .stateHold(stateHold), .resumePc(resumePc), .wakeNoService(wakeNoService),
    .timeBaseService(timeBaseService), .fastOscEnable(fastOscEnable), .slowOscEnable(slowOscEnable),
    .mainClockSlow(mainClockSlow), .periphClockEnable(periphClockEnable),
    .timeBaseClockEnable(timeBaseClockEnable), .sysResetReq(sysResetReq));

//--- test/testbench.sv
// testbench for the standby mode controller; expectations kept in integers
// assumes the controller under core/, the model and checker under test/
`timescale 1ns/1ps
module testbench;
reg clk_sys = 1'h0, rstn = 1'h0, regWrite = 1'h0, regRead = 1'h0, watchdogIrq = 1'h0, clr = 1'h0, tbRun = 1'h0;
reg [3:0] regAddr = 4'h0;
reg [7:0] regWrData = 8'h00, irqEnables = 8'h00, raise = 8'h00;
reg [15:0] cpuPc = 16'h0000;
wire [7:0] regRdData, irqRequests;
wire [15:0] resumePc;
wire cpuRun, watchdogRun, stateHold, wakeNoService, timeBaseService, warmupDoneIrq, timeBaseSrc;
wire fastOscEnable, slowOscEnable, mainClockSlow, periphClockEnable, timeBaseClockEnable, sysResetReq;
integer fails = 0, samples_checked = 0, cyc = 0, nWake = 0, nTb = 0, pmc, m, i;
////////////////////////////////////////////////////////////////////////////
standby_mode_controller dut_u (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .cpuPc(cpuPc), .irqRequests(irqRequests),
    .irqEnables(irqEnables), .watchdogIrq(watchdogIrq), .cpuRun(cpuRun), .watchdogRun(watchdogRun),
    .stateHold(stateHold), .resumePc(resumePc), .wakeNoService(wakeNoService), .timeBaseService(timeBaseService),
    .warmupDoneIrq(warmupDoneIrq), .timeBaseSrc(timeBaseSrc), .fastOscEnable(fastOscEnable),
    .slowOscEnable(slowOscEnable), .mainClockSlow(mainClockSlow), .periphClockEnable(periphClockEnable),
    .timeBaseClockEnable(timeBaseClockEnable), .sysResetReq(sysResetReq));
cpu_side_model model_u (.clk_sys(clk_sys), .rstn(rstn), .raise(raise), .clr(clr), .tbRun(tbRun),
    .irqRequests(irqRequests), .timeBaseSrc(timeBaseSrc));
always #12.5 clk_sys = ~clk_sys;
// pulses counted one edge late so the count never races the wait tasks
always @(posedge clk_sys) begin
    // outputs are unknown before the first reset edge; an unknown would poison the counts
    if (rstn) begin
        nWake <= nWake + wakeNoService;
        nTb <= nTb + timeBaseService;
    end
    cyc = cyc + 1;
    if (cyc == 60000) begin
        fails = fails + 1;
        $display("[ERR] %0t timeout", $time);
        conclude;
    end
end
////////////////////////////////////////////////////////////////////////////
task chk(input [15:0] got, input [15:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    end
endtask
task wr(input [3:0] a, input [7:0] d);
    begin
        @(posedge clk_sys);
        regWrite <= 1'h1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWrite <= 1'h0;
        if (a == 4'h0) pmc = d & 8'hF4;
    end
endtask
task rd(input [3:0] a, input [7:0] exp);
    begin
        @(posedge clk_sys);
        regRead <= 1'h1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'h0;
        @(negedge clk_sys);
        chk(regRdData, exp);
    end
endtask
task waitRun(input v);
    integer k;
    begin
        @(negedge clk_sys);
        for (k = 0; k < 20 && cpuRun !== v; k = k + 1) @(negedge clk_sys);
        chk(cpuRun, v);
    end
endtask
task conclude;
    begin
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    end
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
    i = $urandom(47);
    repeat (8) @(posedge clk_sys);
    rstn <= 1'h1;
    pmc = 8'h80;
    rd(4'h0, pmc);
    rd(4'h6, 8'h01);
    rd(4'hF, 8'h00);
    wr(4'h0, 8'h8B);
    rd(4'h0, pmc);
    $display("reset and register test done");
    for (m = 0; m < 2; m = m + 1) begin
        i = $urandom % 8;
        @(posedge clk_sys) cpuPc <= $urandom;
        irqEnables <= 8'h01 << i;
        wr(4'h2, m);
        wr(4'h0, 8'h90);
        waitRun(0);
        chk({watchdogRun, periphClockEnable}, 2'h1);
        chk(resumePc, cpuPc + 16'h0002);
        @(posedge clk_sys) raise <= 8'h01 << i;
        waitRun(1);
        raise <= 8'h00;
        clr <= 1'h1;
        pmc = pmc & 8'hEB;
        rd(4'h0, pmc);
        clr <= 1'h0;
        chk(nWake, 1);
    end
    $display("cpu halt test done");
    @(posedge clk_sys) watchdogIrq <= 1'h1;
    repeat (3) @(posedge clk_sys);
    wr(4'h0, 8'h90);
    repeat (4) @(negedge clk_sys);
    chk(cpuRun, 1);
    pmc = pmc & 8'hEB;
    rd(4'h0, pmc);
    @(posedge clk_sys) watchdogIrq <= 1'h0;
    $display("watchdog test done");
    for (m = 0; m < 2; m = m + 1) begin
        wr(4'h1, {m[0], 3'h5});
        wr(4'h2, 8'h03);
        wr(4'h0, 8'h84);
        waitRun(0);
        chk({periphClockEnable, timeBaseClockEnable}, 2'h1);
        rd(4'h2, {m[0], 3'h3});
        chk(cpuRun, 0);
        @(posedge clk_sys) tbRun <= 1'h1;
        waitRun(1);
        tbRun <= 1'h0;
        pmc = pmc & 8'hEB;
        rd(4'h0, pmc);
        chk(nTb, m);
        chk(nWake, 2);
    end
    $display("gate halt test done");
    wr(4'h0, 8'hC0);
    wr(4'h0, 8'hE0);
    wr(4'h0, 8'h60);
    repeat (2) @(negedge clk_sys);
    chk({mainClockSlow, fastOscEnable, sysResetReq}, 3'h4);
    wr(4'h0, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk(sysResetReq, 1);
    @(posedge clk_sys) rstn <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    pmc = 8'h80;
    rd(4'h0, pmc);
    $display("clock switch test done");
    wr(4'h3, 8'h43);
    wr(4'h4, 8'h05);
    wr(4'h2, 8'h05);
    wr(4'h5, 8'h40);
    rd(4'h5, 8'h40);
    wr(4'h4, 8'h0D);
    for (i = 0; i < 40000 && warmupDoneIrq !== 1'h1; i = i + 1) @(negedge clk_sys);
    chk(warmupDoneIrq, 1);
    // limit 8040h, one registered stage, and the loop's first look falls on the start edge
    chk(i, 16'h8042);
    rd(4'h2, 8'h15);
    $display("warm-up test done");
    conclude;
end
endmodule // testbench
